// >>> csbe_pkg.sv
// Notes on behaviour
// - equal-compare skip: registers match, so hop over the next instruction
// - compares subtract without writeback; only Z, N, V, C, H change
// - register-bit skips: clear variant skips on 0, set variant on 1
// - io-bit skips: clear variant skips on 0, set variant on 1
// - flag branches: taken loads pc+offset+1, one cycle untaken, two taken
// - carry branches jump on C=1 or C=0, flags untouched
// - same-or-higher jumps on C=0, lower on C=1, flags untouched
package csbe_pkg;
    localparam int PC_W = 16;
    localparam int OFS_W = 7;
    localparam int BIT_W = 3;
    localparam int CNT_W = 2;
    // status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_H = 5;
    localparam int MSB = 7;
    localparam int HALF = 3;
    // skip lengths in program words
    localparam logic [CNT_W-1:0] ONE_WORD = 2'h1;
    localparam logic [CNT_W-1:0] TWO_WORDS = 2'h2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [4:0] {
        nop_op,
        cmp_skip_eq_op,
        compare_reg_op,
        compare_carry_op,
        compare_imm_op,
        skip_reg_bit_clr_op,
        skip_reg_bit_set_op,
        skip_io_bit_clr_op,
        skip_io_bit_set_op,
        branch_flag_set_op,
        branch_flag_clr_op,
        branch_equal_op,
        branch_not_equal_op,
        branch_carry_set_op,
        branch_carry_clr_op,
        branch_same_higher_op,
        branch_lower_op,
        branch_minus_op
    } csbe_op_e;

    // one decoded instruction from the decode stage
    typedef struct packed {
        csbe_op_e op;
        logic [7:0] opa;            // rd, or rr for register-bit skips
        logic [7:0] opb;            // rr or immediate
        logic [7:0] io_val;         // selected io register contents
        logic [BIT_W-1:0] bit_sel;  // bit or status flag index
        logic [OFS_W-1:0] offset;   // signed branch offset
        logic next_two_word;        // following instruction is two words
    } csbe_instr_s;

    typedef enum {
        ST_IDLE,
        ST_SKIP,
        ST_BRANCH
    } csbe_state_e;
endpackage : csbe_pkg

// >>> csbe_exec.sv
`timescale 1ns/1ps
module csbe_exec #(
    parameter int PC_WIDTH = csbe_pkg::PC_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire csbe_pkg::csbe_instr_s instr,
    input wire logic [PC_WIDTH-1:0] pc_in,
    input wire logic [7:0] status_flags_reg,
    output logic busy,
    output logic done,
    output logic flags_we,
    output logic [7:0] flags_out,
    output logic pc_load,
    output logic [PC_WIDTH-1:0] pc_target,
    output logic discard
);
    import csbe_pkg::*;

    typedef struct packed {
        csbe_state_e state;
        logic [CNT_W-1:0] skip_cnt;
        logic busy;
        logic done;
        logic flags_we;
        logic [7:0] flags;
        logic pc_load;
        logic [PC_WIDTH-1:0] pc_target;
        logic discard;
    } csbe_st_s;

    csbe_st_s st_ff;
    csbe_st_s nxt_st;

    // subtract and return the new status byte
    function automatic logic [7:0] sub_flags(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic cin,
                                             input logic chain_z,
                                             input logic [7:0] sin);
        logic [7:0] r;
        logic [7:0] f;
        r = a - b - {7'h00, cin};
        f = sin;
        f[FLG_H] = (~a[HALF] & b[HALF]) | (b[HALF] & r[HALF])
                 | (r[HALF] & ~a[HALF]);
        f[FLG_V] = (a[MSB] & ~b[MSB] & ~r[MSB])
                 | (~a[MSB] & b[MSB] & r[MSB]);
        f[FLG_N] = r[MSB];
        f[FLG_C] = (~a[MSB] & b[MSB]) | (b[MSB] & r[MSB])
                 | (r[MSB] & ~a[MSB]);
        // carry-compare keeps a zero only when all previous bytes were zero
        f[FLG_Z] = (r == BYTE_ZERO) & (chain_z ? sin[FLG_Z] : 1'b1);
        return f;
    endfunction

    // branch condition for every branch form
    function automatic logic branch_cond(input csbe_op_e op,
                                         input logic [7:0] s,
                                         input logic [BIT_W-1:0] sel);
        case (op)
            branch_flag_set_op: return s[sel];
            branch_flag_clr_op: return ~s[sel];
            branch_equal_op: return s[FLG_Z];
            branch_not_equal_op: return ~s[FLG_Z];
            branch_carry_set_op: return s[FLG_C];
            branch_carry_clr_op: return ~s[FLG_C];
            branch_same_higher_op: return ~s[FLG_C];
            branch_lower_op: return s[FLG_C];
            branch_minus_op: return s[FLG_N];
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic is_branch(input csbe_op_e op);
        return (op >= branch_flag_set_op) && (op <= branch_minus_op);
    endfunction

    // next state: decode, execute, then count out skips and branch flush
    always_comb begin
        logic skip;
        logic [PC_WIDTH-1:0] ofs_ext;
        skip = 1'b0;
        ofs_ext = {{(PC_WIDTH-OFS_W){instr.offset[OFS_W-1]}}, instr.offset};
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.flags_we = 1'b0;
        nxt_st.pc_load = 1'b0;
        nxt_st.discard = 1'b0;
        case (st_ff.state)
            ST_IDLE: begin
                if (issue_valid) begin
                    nxt_st.flags = status_flags_reg;
                    case (instr.op)
                        cmp_skip_eq_op:
                            skip = (instr.opa == instr.opb);
                        compare_reg_op, compare_imm_op: begin
                            nxt_st.flags_we = 1'b1;
                            nxt_st.flags = sub_flags(instr.opa, instr.opb,
                                1'b0, 1'b0, status_flags_reg);
                        end
                        compare_carry_op: begin
                            nxt_st.flags_we = 1'b1;
                            nxt_st.flags = sub_flags(instr.opa, instr.opb,
                                status_flags_reg[FLG_C], 1'b1,
                                status_flags_reg);
                        end
                        skip_reg_bit_clr_op:
                            skip = ~instr.opa[instr.bit_sel];
                        skip_reg_bit_set_op:
                            skip = instr.opa[instr.bit_sel];
                        skip_io_bit_clr_op:
                            skip = ~instr.io_val[instr.bit_sel];
                        skip_io_bit_set_op:
                            skip = instr.io_val[instr.bit_sel];
                        default: skip = 1'b0;
                    endcase
                    if (is_branch(instr.op) &&
                        branch_cond(instr.op, status_flags_reg,
                                    instr.bit_sel)) begin
                        nxt_st.pc_load = 1'b1;
                        nxt_st.pc_target = pc_in + ofs_ext
                            + {{(PC_WIDTH-1){1'b0}}, 1'b1};
                        nxt_st.state = ST_BRANCH;
                        nxt_st.busy = 1'b1;
                    end else if (skip) begin
                        nxt_st.skip_cnt = instr.next_two_word ?
                            TWO_WORDS : ONE_WORD;
                        nxt_st.state = ST_SKIP;
                        nxt_st.busy = 1'b1;
                    end else begin
                        nxt_st.done = 1'b1;
                    end
                end
            end
            ST_SKIP: begin
                nxt_st.discard = 1'b1;
                nxt_st.skip_cnt = st_ff.skip_cnt - ONE_WORD;
                if (st_ff.skip_cnt == ONE_WORD) begin
                    nxt_st.state = ST_IDLE;
                    nxt_st.busy = 1'b0;
                    nxt_st.done = 1'b1;
                end
            end
            ST_BRANCH: begin
                nxt_st.state = ST_IDLE;
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
            default: begin
                nxt_st.state = ST_IDLE;
                nxt_st.busy = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.state <= ST_IDLE;
            st_ff.skip_cnt <= CNT_ZERO;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign busy = st_ff.busy;
    assign done = st_ff.done;
    assign flags_we = st_ff.flags_we;
    assign flags_out = st_ff.flags;
    assign pc_load = st_ff.pc_load;
    assign pc_target = st_ff.pc_target;
    assign discard = st_ff.discard;
endmodule // csbe_exec

// >>> csbe_exec_props.sv
`timescale 1ns/1ps
module csbe_exec_props #(
    parameter int PC_WIDTH = csbe_pkg::PC_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire csbe_pkg::csbe_instr_s instr,
    input wire logic [PC_WIDTH-1:0] pc_in,
    input wire logic [7:0] status_flags_reg,
    input wire logic busy,
    input wire logic done,
    input wire logic flags_we,
    input wire logic [7:0] flags_out,
    input wire logic pc_load,
    input wire logic [PC_WIDTH-1:0] pc_target,
    input wire logic discard
);
    import csbe_pkg::*;
    logic tk;
    logic [PC_WIDTH-1:0] tgt;
    // accepted issue and the branch target it implies
    assign tk = issue_valid && !busy;
    assign tgt = pc_in + PC_WIDTH'($signed(instr.offset)) + 1'b1;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_cmp_flag_pulse: assert property (
        tk && instr.op inside
        {compare_reg_op, compare_carry_op, compare_imm_op}
        |=> flags_we && done && !pc_load) else $error("compare pulse");
    a_cmp_zero_flag: assert property (
        tk && instr.op == compare_reg_op
        |=> flags_out[FLG_Z] == $past(instr.opa == instr.opb))
        else $error("compare zero flag");
    a_eq_skip_one: assert property (
        tk && instr.op == cmp_skip_eq_op
        && instr.opa == instr.opb && !instr.next_two_word
        |=> busy ##1 discard && done && !busy) else $error("equal skip");
    a_skip_two_words: assert property (
        tk && instr.next_two_word
        && instr.op == skip_io_bit_set_op && instr.io_val[instr.bit_sel]
        |=> busy ##1 discard [*2] ##0 done) else $error("two word skip");
    a_reg_bit_stay: assert property (
        tk && !instr.opa[instr.bit_sel] && instr.op == skip_reg_bit_set_op
        |=> done && !busy && !discard) else $error("reg bit skip");
    a_io_bit_skip: assert property (
        tk && !instr.io_val[instr.bit_sel] && instr.op == skip_io_bit_clr_op
        |=> busy ##1 discard) else $error("io bit skip");
    a_branch_target: assert property (
        tk && instr.op == branch_flag_set_op
        && status_flags_reg[instr.bit_sel]
        |=> pc_load && pc_target == $past(tgt) ##1 done)
        else $error("branch target");
    a_carry_clr_jump: assert property (
        tk && instr.op == branch_carry_clr_op
        |=> pc_load == !$past(status_flags_reg[FLG_C]) && !flags_we)
        else $error("carry clear branch");
    a_lower_jump: assert property (
        tk && instr.op == branch_lower_op
        |=> pc_load == $past(status_flags_reg[FLG_C]))
        else $error("lower branch");
endmodule // csbe_exec_props
bind csbe_exec csbe_exec_props #(.PC_WIDTH(PC_WIDTH)) csbe_exec_props_inst (
    .core_clk(core_clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .instr(instr), .pc_in(pc_in), .status_flags_reg(status_flags_reg),
    .busy(busy), .done(done), .flags_we(flags_we), .flags_out(flags_out),
    .pc_load(pc_load), .pc_target(pc_target), .discard(discard));

// >>> test_compare_skip_branch_exec.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module test_compare_skip_branch_exec;
    import csbe_pkg::*;
    logic core_clk, rst_n, issue_valid, busy, done, flags_we, pc_load, discard;
    csbe_instr_s instr;
    logic [15:0] pc_in, pc_target;
    logic [7:0] status_flags_reg, flags_out, fl;
    int errors, checks, cyc;
    csbe_exec csbe_exec_inst (.core_clk(core_clk), .rst_n(rst_n),
        .issue_valid(issue_valid), .instr(instr), .pc_in(pc_in),
        .status_flags_reg(status_flags_reg), .busy(busy), .done(done),
        .flags_we(flags_we), .flags_out(flags_out), .pc_load(pc_load),
        .pc_target(pc_target), .discard(discard));
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            errors++;
            final_report();
        end
    end
    task final_report();
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // issue one instruction, follow it to done, tally its pulses
    task automatic go(csbe_op_e op, logic [7:0] a, logic [7:0] b,
            logic [7:0] f, int d, int p);
        int k = 0, dc = 0, pc = 0, wc = 0, bc = 0;
        int cw;
        cw = int'(op inside {compare_reg_op, compare_carry_op,
            compare_imm_op});
        @(posedge core_clk);
        instr <= '{op, a, b, a, 3'h1, 7'h7e, d == 2};
        status_flags_reg <= f;
        issue_valid <= 1'b1;
        @(posedge core_clk);
        issue_valid <= 1'b0;
        repeat (5) begin
            #1;
            k++;
            dc += discard;
            pc += pc_load;
            wc += flags_we;
            bc += busy;
            if (flags_we === 1'b1) fl = flags_out;
            if (done === 1'b1) break;
            @(posedge core_clk);
        end
        `CHK(k, 1 + d + p)
        `CHK(dc, d)
        `CHK(bc, d + p)
        `CHK(pc, p)
        `CHK(wc, cw)
        if (pc != 0) `CHK(pc_target, 16'h00ff)
    endtask
    task t_compare();
        go(compare_reg_op, 8'h10, 8'h10, 8'h10, 0, 0);
        `CHK(fl, 8'h12)
        go(compare_imm_op, 8'h00, 8'h01, 8'h10, 0, 0);
        `CHK(fl, 8'h35)
        go(compare_carry_op, 8'h05, 8'h05, 8'h03, 0, 0);
        `CHK(fl, 8'h25)
    endtask
    task t_skip();
        go(cmp_skip_eq_op, 8'h5a, 8'h5a, 8'h00, 1, 0);
        go(cmp_skip_eq_op, 8'h5a, 8'h5a, 8'h00, 2, 0);
        go(cmp_skip_eq_op, 8'h5a, 8'h5b, 8'h00, 0, 0);
        go(skip_reg_bit_clr_op, 8'hfd, 8'h00, 8'h00, 1, 0);
        go(skip_reg_bit_set_op, 8'hfd, 8'h00, 8'h00, 0, 0);
        go(skip_io_bit_clr_op, 8'hfd, 8'h00, 8'h00, 1, 0);
        go(skip_io_bit_set_op, 8'h02, 8'h00, 8'h00, 2, 0);
    endtask
    // issue while busy is ignored, then a reset lands on the edge that ends a two-word skip and clears its done
    task t_reset();
        @(posedge core_clk);
        instr <= '{skip_io_bit_set_op, 8'h02, 8'h00, 8'h02, 3'h1, 7'h7e,
            1'b1};
        issue_valid <= 1'b1;
        @(posedge core_clk);
        instr.op <= compare_reg_op;
        @(posedge core_clk);
        #1;
        `CHK({busy, discard, flags_we}, 3'b110)
        @(posedge core_clk);
        rst_n <= 1'b0;
        issue_valid <= 1'b0;
        #1;
        `CHK({busy, done, discard, pc_load, flags_we, flags_out}, 13'h0000)
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK({busy, done, discard, pc_load, flags_we, flags_out}, 13'h0000)
    endtask
    task t_branch();
        go(branch_flag_set_op, 8'h00, 8'h00, 8'h02, 0, 1);
        go(branch_flag_clr_op, 8'h00, 8'h00, 8'h02, 0, 0);
        go(branch_equal_op, 8'h00, 8'h00, 8'h02, 0, 1);
        go(branch_not_equal_op, 8'h00, 8'h00, 8'h02, 0, 0);
        go(branch_minus_op, 8'h00, 8'h00, 8'h04, 0, 1);
        go(branch_carry_set_op, 8'h00, 8'h00, 8'h01, 0, 1);
        go(branch_carry_clr_op, 8'h00, 8'h00, 8'h01, 0, 0);
        go(branch_same_higher_op, 8'h00, 8'h00, 8'h00, 0, 1);
        go(branch_lower_op, 8'h00, 8'h00, 8'h00, 0, 0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        issue_valid = 1'b0;
        instr = '0;
        pc_in = 16'h0100;
        status_flags_reg = 8'h00;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_compare();
        t_skip();
        t_reset();
        t_branch();
        final_report();
    end
endmodule // test_compare_skip_branch_exec
